/* rtl/usbd_desc_rom.sv */
// Descriptor byte store for device and configuration descriptors
`timescale 1ns/1ps
module usbd_desc_rom #(
	parameter logic [15:0] VENDOR_ID = 16'h1234, // Arbitrary value
	parameter logic [15:0] RELEASE = usbd_pkg::BCD_DEVICE,
	parameter logic [7:0] MANUF_IDX = usbd_pkg::STR_MANUF,
	parameter logic [7:0] PRODUCT_IDX = usbd_pkg::STR_PRODUCT,
	parameter logic [7:0] SERIAL_IDX = usbd_pkg::STR_SERIAL
) (
	input wire usbd_pkg::usbd_src_t src,
	input wire logic [6:0] idx,
	input wire logic [15:0] productId,
	output logic [7:0] data
);
	localparam int DEV_BYTES = int'(usbd_pkg::DEV_LEN);
	localparam int CFG_BYTES = int'(usbd_pkg::CFG_TOTAL);

	function automatic logic [15:0] le16(input logic [15:0] v);
		return {v[7:0], v[15:8]};
	endfunction

	// Seven-byte endpoint record
	function automatic logic [55:0] epDesc(input logic [7:0] addr,
		input logic [7:0] attr, input logic [7:0] interval);
		return {usbd_pkg::EP_LEN, usbd_pkg::TYPE_ENDPOINT, addr, attr,
			le16(usbd_pkg::EP_MAXP), interval};
	endfunction

	logic [8*DEV_BYTES-1:0] devBlob;
	logic [8*CFG_BYTES-1:0] cfgBlob;
	int pos;

	// Length then type lead every record
	assign devBlob = {usbd_pkg::DEV_LEN, usbd_pkg::TYPE_DEVICE,
		le16(usbd_pkg::BCD_USB), usbd_pkg::DEV_CLASS,
		usbd_pkg::DEV_SUBCLASS, usbd_pkg::DEV_PROTOCOL,
		usbd_pkg::EP0_MAX, le16(VENDOR_ID), le16(productId),
		le16(RELEASE), MANUF_IDX, PRODUCT_IDX, SERIAL_IDX,
		usbd_pkg::NUM_CONFIGS};

	// Whole configuration set in one image
	assign cfgBlob = {usbd_pkg::CFG_LEN, usbd_pkg::TYPE_CONFIG,
		le16(usbd_pkg::CFG_TOTAL), usbd_pkg::NUM_IFACES,
		usbd_pkg::CFG_VALUE, usbd_pkg::STR_CONFIG,
		usbd_pkg::CFG_ATTR, usbd_pkg::CFG_POWER,
		usbd_pkg::IF_LEN, usbd_pkg::TYPE_IFACE, usbd_pkg::NONE,
		usbd_pkg::NONE, usbd_pkg::IF0_EPS, usbd_pkg::IF0_CLASS,
		usbd_pkg::NONE, usbd_pkg::NONE, usbd_pkg::STR_IFACE,
		epDesc(usbd_pkg::EP_IN | usbd_pkg::EP_BULK_A, usbd_pkg::XFER_BULK,
			usbd_pkg::EP_NO_POLL),
		epDesc(usbd_pkg::EP_BULK_A, usbd_pkg::XFER_BULK, usbd_pkg::EP_NO_POLL),
		epDesc(usbd_pkg::EP_IN | usbd_pkg::EP_BULK_B, usbd_pkg::XFER_BULK,
			usbd_pkg::EP_NO_POLL),
		epDesc(usbd_pkg::EP_BULK_B, usbd_pkg::XFER_BULK, usbd_pkg::EP_NO_POLL),
		usbd_pkg::IF_LEN, usbd_pkg::TYPE_IFACE, usbd_pkg::IF1_NUM,
		usbd_pkg::NONE, usbd_pkg::IF1_EPS, usbd_pkg::IF1_CLASS,
		usbd_pkg::IF1_SUBCLASS, usbd_pkg::IF1_PROTOCOL, usbd_pkg::NONE,
		usbd_pkg::CS_BLOB,
		epDesc(usbd_pkg::EP_IN | usbd_pkg::EP_INTR, usbd_pkg::XFER_INTR,
			usbd_pkg::EP2_INTERVAL),
		usbd_pkg::VENDOR_BLOB};

	always_comb begin
		pos = 0;
		data = 8'h00;
		if (src == usbd_pkg::SRC_DEVICE && int'(idx) < DEV_BYTES) begin
			pos = 8 * (DEV_BYTES - 1 - int'(idx));
			data = devBlob[pos +: 8];
		end else if (src == usbd_pkg::SRC_CONFIG && int'(idx) < CFG_BYTES) begin
			pos = 8 * (CFG_BYTES - 1 - int'(idx));
			data = cfgBlob[pos +: 8];
		end
	end
endmodule

/* rtl/usbd_dev_state.sv */
// Function address and current configuration holder
`timescale 1ns/1ps
module usbd_dev_state (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic setupValid,
	input wire logic setAddrReq,
	input wire logic setCfgReq,
	input wire logic [7:0] reqValue,
	input wire logic statusDone,
	output logic [6:0] address,
	output logic [7:0] currentConfig,
	output logic configured,
	output logic [3:0] epEnable
);
	typedef struct packed {
		logic pendAddr;
		logic pendCfg;
		logic [7:0] hold;
		logic [6:0] address;
		logic [7:0] cfgValue;
		logic configured;
		logic [3:0] epEnable;
	} usbd_dev_t;
	usbd_dev_t state_reg, state_next;

	always_comb begin
		state_next = state_reg;
		if (setAddrReq) begin
			state_next.pendAddr = 1'b1;
			state_next.pendCfg = 1'b0;
			state_next.hold = reqValue;
		end else if (setCfgReq) begin
			state_next.pendCfg = 1'b1;
			state_next.pendAddr = 1'b0;
			state_next.hold = reqValue;
		end else if (setupValid) begin
			state_next.pendAddr = 1'b0;
			state_next.pendCfg = 1'b0;
		end else if (statusDone) begin
			state_next.pendAddr = 1'b0;
			state_next.pendCfg = 1'b0;
			if (state_reg.pendAddr) begin
				state_next.address = state_reg.hold[6:0];
			end
			if (state_reg.pendCfg) begin
				state_next.cfgValue = state_reg.hold;
			end
		end
		state_next.configured = state_next.cfgValue != 8'h00;
		state_next.epEnable = {{3{state_next.configured}}, 1'b1};
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state_reg <= '{epEnable: 4'h1, default: '0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign address = state_reg.address;
	assign currentConfig = state_reg.cfgValue;
	assign configured = state_reg.configured;
	assign epEnable = state_reg.epEnable;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	a_addr_defer: assert property (state_reg.pendAddr && !statusDone &&
		!setAddrReq |=> $stable(address)) else $error("address moved early");
	a_addr_apply: assert property (state_reg.pendAddr && statusDone &&
		!setupValid |=> address == $past(state_reg.hold[6:0]))
		else $error("address not taken");
	a_cfg_adopt: assert property (setCfgReq ##1 (!setupValid)[*1] ##0
		statusDone |=> currentConfig == $past(state_reg.hold))
		else $error("configuration not adopted");
	a_ep_enable: assert property (configured |-> epEnable == 4'hF)
		else $error("endpoints not enabled");
endmodule

/* rtl/usbd_enum_ctrl.sv */
// Control endpoint engine answering enumeration requests
`timescale 1ns/1ps
// Summary of operation
// - Every descriptor starts with its byte length then its type code.
// - Related class and vendor descriptors travel inside the configuration set.
// - Device descriptor: length 0x12, type 0x01, release 0x0110.
// - Device class 0x02, subclass 0x00, protocol 0xFF.
// - Control endpoint packet size reported as 0x40.
// - Release 0x0100, string indexes 1, 2, 0, one configuration.
// - Vendor, product, release and strings set at build; product id loaded.
// - Configuration: length 9, type 2, total 0x0057, two interfaces.
// - Attribute byte 0xA0 with low five bits zero.
// - Maximum power byte 0x7D in 2 mA steps.
// - Losing external power clears the self-powered status bit.
// - Interface 0: four endpoints, class 0x0A, string index 4.
// - Configuration request returns all interface and endpoint records.
// - Endpoint address: number low nibble, bit 7 direction.
// - Endpoint attribute low two bits give transfer type.
// - Bulk endpoints 1 and 3, 64-byte packets, zero interval.
// - Interval ignored for bulk, nonzero for interrupt endpoints.
// - Endpoint 0 control, 1 and 3 bulk, 2 interrupt, 64 bytes.
// - Set-configuration value becomes the current configuration.
// - A short packet ends the transfer.
module usbd_enum_ctrl #(
	parameter logic [15:0] VENDOR_ID = 16'h1234, // Arbitrary value
	parameter logic [15:0] PRODUCT_ID_INIT = 16'h0000, // Arbitrary value
	parameter logic [15:0] RELEASE = usbd_pkg::BCD_DEVICE
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic setupValid,
	input wire usbd_pkg::usbd_setup_t setup,
	input wire logic inReq,
	input wire logic statusDone,
	input wire logic extPowerGood,
	input wire logic productIdValid,
	input wire logic [15:0] productIdIn,
	output usbd_pkg::usbd_tx_t tx,
	output logic stall,
	output logic selfPowered,
	output logic [6:0] address,
	output logic [7:0] currentConfig,
	output logic configured,
	output logic [3:0] epEnable
);
	localparam logic [6:0] PKT_LAST = 7'(usbd_pkg::EP0_MAX) - 7'h01;
	localparam logic [15:0] PKT_MASK = 16'(usbd_pkg::EP0_MAX) - 16'h0001;

	typedef struct packed {
		usbd_pkg::usbd_phase_t phase;
		usbd_pkg::usbd_src_t src;
		logic [6:0] ptr;
		logic [6:0] pktCount;
		logic [15:0] remain;
		logic needZlp;
		logic [15:0] reply;
		logic [15:0] productId;
		logic selfPowered;
		logic stall;
		usbd_pkg::usbd_tx_t tx;
	} usbd_ctrl_t;

	usbd_ctrl_t state_reg, state_next;
	logic [7:0] romByte;
	logic [7:0] curByte;
	logic setAddrReq;
	logic setCfgReq;
	logic [15:0] dataLen;
	logic accept;
	logic dataIn;
	logic isStd;
	logic [7:0] descType;

	function automatic logic [15:0] minLen(input logic [15:0] a,
		input logic [15:0] b);
		return (a < b) ? a : b;
	endfunction

	function automatic logic wholePkts(input logic [15:0] len);
		return (len & PKT_MASK) == 16'h0000;
	endfunction

	usbd_desc_rom #(
		.VENDOR_ID(VENDOR_ID),
		.RELEASE(RELEASE),
		.MANUF_IDX(usbd_pkg::STR_MANUF),
		.PRODUCT_IDX(usbd_pkg::STR_PRODUCT),
		.SERIAL_IDX(usbd_pkg::STR_SERIAL)
	) u_rom (
		.src(state_reg.src),
		.idx(state_reg.ptr),
		.productId(state_reg.productId),
		.data(romByte)
	);

	usbd_dev_state u_state (
		.clock(clock),
		.reset_n(reset_n),
		.setupValid(setupValid),
		.setAddrReq(setAddrReq),
		.setCfgReq(setCfgReq),
		.reqValue(setup.value[7:0]),
		.statusDone(statusDone),
		.address(address),
		.currentConfig(currentConfig),
		.configured(configured),
		.epEnable(epEnable)
	);

	// Byte source for the data stage
	always_comb begin
		curByte = romByte;
		if (state_reg.src == usbd_pkg::SRC_REPLY) begin
			curByte = state_reg.ptr[0] ? state_reg.reply[15:8] :
				state_reg.reply[7:0];
		end
	end

	always_comb begin
		state_next = state_reg;
		state_next.tx = '0;
		setAddrReq = 1'b0;
		setCfgReq = 1'b0;
		dataLen = 16'h0000;
		accept = 1'b0;
		dataIn = 1'b0;
		isStd = setup.reqType[6:5] == 2'b00;
		descType = setup.value[15:8];
		// Self-powered only while the local supply holds
		state_next.selfPowered = usbd_pkg::CFG_ATTR[usbd_pkg::ATTR_SELF_BIT] &
			extPowerGood;
		if (productIdValid) begin
			state_next.productId = productIdIn;
		end
		case (state_reg.phase)
			usbd_pkg::PH_SEND: begin
				state_next.tx.valid = 1'b1;
				state_next.tx.data = curByte;
				state_next.ptr = state_reg.ptr + 7'h01;
				state_next.remain = state_reg.remain - 16'h0001;
				state_next.pktCount = state_reg.pktCount + 7'h01;
				// Packets never exceed the control packet size
				if (state_reg.remain == 16'h0001 ||
					state_reg.pktCount == PKT_LAST) begin
					state_next.tx.last = 1'b1;
					state_next.pktCount = 7'h00;
					if (state_reg.remain == 16'h0001 && !state_reg.needZlp) begin
						state_next.phase = usbd_pkg::PH_STATUS;
					end else begin
						state_next.phase = usbd_pkg::PH_WAIT_IN;
					end
				end
			end
			usbd_pkg::PH_WAIT_IN: begin
				if (inReq) begin
					if (state_reg.remain == 16'h0000) begin
						// Zero-length packet closes a whole-packet reply
						state_next.tx.zlp = 1'b1;
						state_next.needZlp = 1'b0;
						state_next.phase = usbd_pkg::PH_STATUS;
					end else begin
						state_next.phase = usbd_pkg::PH_SEND;
					end
				end
			end
			usbd_pkg::PH_STATUS: begin
				if (statusDone) begin
					state_next.phase = usbd_pkg::PH_IDLE;
				end
			end
			default: begin
			end
		endcase
		// A new setup aborts whatever was in progress
		if (setupValid) begin
			state_next.tx = '0;
			state_next.stall = 1'b0;
			state_next.ptr = 7'h00;
			state_next.pktCount = 7'h00;
			state_next.needZlp = 1'b0;
			state_next.remain = 16'h0000;
			state_next.reply = 16'h0000;
			state_next.src = usbd_pkg::SRC_REPLY;
			if (!isStd) begin
				accept = 1'b0;
			end else if (setup.request == usbd_pkg::REQ_GET_DESC &&
				setup.reqType[7]) begin
				if (descType == usbd_pkg::TYPE_DEVICE) begin
					state_next.src = usbd_pkg::SRC_DEVICE;
					dataLen = 16'(usbd_pkg::DEV_LEN);
					accept = 1'b1;
					dataIn = 1'b1;
				end else if (descType == usbd_pkg::TYPE_CONFIG) begin
					state_next.src = usbd_pkg::SRC_CONFIG;
					dataLen = usbd_pkg::CFG_TOTAL;
					accept = 1'b1;
					dataIn = 1'b1;
				end
			end else if (setup.request == usbd_pkg::REQ_GET_STATUS &&
				setup.reqType[7]) begin
				if (setup.reqType[4:0] == 5'h00) begin
					state_next.reply = {15'h0000, state_reg.selfPowered};
				end
				dataLen = 16'h0002;
				accept = 1'b1;
				dataIn = 1'b1;
			end else if (setup.request == usbd_pkg::REQ_GET_CONFIG &&
				setup.reqType[7]) begin
				state_next.reply = {8'h00, currentConfig};
				dataLen = 16'h0001;
				accept = 1'b1;
				dataIn = 1'b1;
			end else if (setup.request == usbd_pkg::REQ_SET_ADDRESS) begin
				setAddrReq = 1'b1;
				accept = 1'b1;
			end else if (setup.request == usbd_pkg::REQ_SET_CONFIG) begin
				if (setup.value[7:0] == 8'h00 ||
					setup.value[7:0] == usbd_pkg::CFG_VALUE) begin
					setCfgReq = 1'b1;
					accept = 1'b1;
				end
			end
			if (!accept) begin
				state_next.stall = 1'b1;
				state_next.phase = usbd_pkg::PH_STALL;
			end else if (dataIn) begin
				// Lesser of asked and stored length
				state_next.remain = minLen(setup.length, dataLen);
				state_next.needZlp = minLen(setup.length, dataLen) < setup.length &&
					wholePkts(minLen(setup.length, dataLen));
				state_next.phase = (setup.length == 16'h0000) ?
					usbd_pkg::PH_STATUS : usbd_pkg::PH_WAIT_IN;
			end else begin
				state_next.phase = usbd_pkg::PH_STATUS;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state_reg <= '{phase: usbd_pkg::PH_IDLE, src: usbd_pkg::SRC_REPLY,
				productId: PRODUCT_ID_INIT, default: '0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign tx = state_reg.tx;
	assign stall = state_reg.stall;
	assign selfPowered = state_reg.selfPowered;

	// Checking helpers
	logic [6:0] runLen_reg;
	logic [15:0] sent_reg;
	logic [15:0] asked_reg;
	logic sending;
	assign sending = state_reg.phase == usbd_pkg::PH_SEND && !setupValid;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			runLen_reg <= 7'h00;
			sent_reg <= 16'h0000;
			asked_reg <= 16'h0000;
		end else begin
			runLen_reg <= (tx.valid && !tx.last) ? runLen_reg + 7'h01 : 7'h00;
			if (setupValid) begin
				sent_reg <= 16'h0000;
				asked_reg <= setup.length;
			end else if (tx.valid) begin
				sent_reg <= sent_reg + 16'h0001;
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	property byteAt(usbd_pkg::usbd_src_t s, logic [6:0] i, logic [7:0] v);
		sending && state_reg.src == s && state_reg.ptr == i |=> tx.data == v;
	endproperty

	a_dev_header: assert property (byteAt(usbd_pkg::SRC_DEVICE, 7'h00,
		usbd_pkg::DEV_LEN)) else $error("device length byte wrong");
	a_cfg_type: assert property (sending &&
		state_reg.src == usbd_pkg::SRC_CONFIG && state_reg.ptr == 7'h01
		|=> tx.valid && tx.data == usbd_pkg::TYPE_CONFIG)
		else $error("configuration type byte wrong");
	a_usb_release: assert property (byteAt(usbd_pkg::SRC_DEVICE, 7'h03,
		usbd_pkg::BCD_USB[15:8])) else $error("release byte wrong");
	a_dev_protocol: assert property (byteAt(usbd_pkg::SRC_DEVICE, 7'h06,
		usbd_pkg::DEV_PROTOCOL)) else $error("protocol byte wrong");
	a_ep0_size: assert property (byteAt(usbd_pkg::SRC_DEVICE, 7'h07,
		usbd_pkg::EP0_MAX)) else $error("packet size byte wrong");
	a_cfg_total: assert property (byteAt(usbd_pkg::SRC_CONFIG, 7'h02,
		usbd_pkg::CFG_TOTAL[7:0])) else $error("total length byte wrong");
	a_cfg_attr: assert property (sending &&
		state_reg.src == usbd_pkg::SRC_CONFIG && state_reg.ptr == 7'h07
		|=> tx.data[4:0] == 5'h00 && tx.data[7])
		else $error("attribute byte wrong");
	a_cfg_power: assert property (byteAt(usbd_pkg::SRC_CONFIG, 7'h08,
		usbd_pkg::CFG_POWER)) else $error("power byte wrong");
	a_if_count: assert property (byteAt(usbd_pkg::SRC_CONFIG, 7'h0D,
		usbd_pkg::IF0_EPS)) else $error("endpoint count wrong");
	a_ep_addr: assert property (sending &&
		state_reg.src == usbd_pkg::SRC_CONFIG && state_reg.ptr == 7'h14
		|=> tx.data[6:4] == 3'h0 && tx.data[7] && tx.data[3:0] == 4'h1)
		else $error("endpoint address wrong");
	a_ep_type: assert property (byteAt(usbd_pkg::SRC_CONFIG, 7'h15,
		usbd_pkg::XFER_BULK)) else $error("transfer type wrong");
	a_bulk_maxp: assert property (byteAt(usbd_pkg::SRC_CONFIG, 7'h2B,
		usbd_pkg::EP_MAXP[7:0])) else $error("bulk packet size wrong");
	a_intr_poll: assert property (sending &&
		state_reg.src == usbd_pkg::SRC_CONFIG && state_reg.ptr == 7'h50
		|=> tx.data != 8'h00) else $error("interrupt interval zero");
	a_pkt_limit: assert property (tx.valid |-> runLen_reg <= PKT_LAST)
		else $error("packet too long");
	a_len_clamp: assert property (tx.valid |-> sent_reg < asked_reg)
		else $error("more bytes than asked");
	a_short_end: assert property (tx.valid && tx.last &&
		runLen_reg != PKT_LAST |-> state_reg.phase == usbd_pkg::PH_STATUS)
		else $error("short packet did not end transfer");
	a_whole_cfg: assert property (setupValid &&
		setup.request == usbd_pkg::REQ_GET_DESC && setup.reqType == 8'h80 &&
		setup.value[15:8] == usbd_pkg::TYPE_CONFIG &&
		setup.length >= usbd_pkg::CFG_TOTAL
		|=> state_reg.remain == usbd_pkg::CFG_TOTAL)
		else $error("configuration set cut short");
	a_self_power: assert property (!extPowerGood |=> !selfPowered)
		else $error("self powered while supply lost");
	a_bad_stall: assert property (setupValid &&
		setup.reqType[6:5] != 2'b00
		|=> stall ##1 (stall || $past(setupValid)))
		else $error("foreign request not stalled");

	c_dev_desc: cover property (sending &&
		state_reg.src == usbd_pkg::SRC_DEVICE ##1 tx.last);
	c_cfg_two_pkts: cover property (tx.valid && tx.last &&
		runLen_reg == PKT_LAST ##[1:100] tx.valid && tx.last);
	c_zlp: cover property (tx.zlp);
	c_set_addr: cover property (setAddrReq ##[1:20] statusDone);
endmodule

/* rtl/usbd_pkg.sv */
// Constants and types shared by the descriptor enumeration block
package usbd_pkg;
	localparam logic [7:0] NONE = 8'h00;
	localparam logic [7:0] DEV_LEN = 8'h12;
	localparam logic [7:0] TYPE_DEVICE = 8'h01;
	localparam logic [15:0] BCD_USB = 16'h0110;
	localparam logic [7:0] DEV_CLASS = 8'h02;
	localparam logic [7:0] DEV_SUBCLASS = 8'h00;
	localparam logic [7:0] DEV_PROTOCOL = 8'hFF;
	localparam logic [7:0] EP0_MAX = 8'h40;
	localparam logic [15:0] BCD_DEVICE = 16'h0100;
	localparam logic [7:0] STR_MANUF = 8'h01;
	localparam logic [7:0] STR_PRODUCT = 8'h02;
	localparam logic [7:0] STR_SERIAL = 8'h00;
	localparam logic [7:0] NUM_CONFIGS = 8'h01;
	localparam logic [7:0] CFG_LEN = 8'h09;
	localparam logic [7:0] TYPE_CONFIG = 8'h02;
	localparam logic [15:0] CFG_TOTAL = 16'h0057;
	localparam logic [7:0] NUM_IFACES = 8'h02;
	localparam logic [7:0] CFG_VALUE = 8'h01;
	localparam logic [7:0] STR_CONFIG = 8'h03;
	localparam logic [7:0] CFG_ATTR = 8'hA0;
	localparam int ATTR_SELF_BIT = 6;
	localparam logic [7:0] CFG_POWER = 8'h7D;
	localparam logic [7:0] IF_LEN = 8'h09;
	localparam logic [7:0] TYPE_IFACE = 8'h04;
	localparam logic [7:0] IF0_EPS = 8'h04;
	localparam logic [7:0] IF0_CLASS = 8'h0A;
	localparam logic [7:0] STR_IFACE = 8'h04;
	localparam logic [7:0] IF1_NUM = 8'h01;
	localparam logic [7:0] IF1_EPS = 8'h01;
	localparam logic [7:0] IF1_CLASS = 8'h02;
	localparam logic [7:0] IF1_SUBCLASS = 8'h02;
	localparam logic [7:0] IF1_PROTOCOL = 8'h01;
	localparam logic [7:0] EP_LEN = 8'h07;
	localparam logic [7:0] TYPE_ENDPOINT = 8'h05;
	localparam logic [7:0] EP_IN = 8'h80;
	localparam logic [7:0] EP_BULK_A = 8'h01;
	localparam logic [7:0] EP_INTR = 8'h02;
	localparam logic [7:0] EP_BULK_B = 8'h03;
	localparam logic [7:0] XFER_BULK = 8'h02;
	localparam logic [7:0] XFER_INTR = 8'h03;
	localparam logic [15:0] EP_MAXP = 16'h0040;
	localparam logic [7:0] EP_NO_POLL = 8'h00;
	localparam logic [7:0] EP2_INTERVAL = 8'h01;
	localparam logic [151:0] CS_BLOB =
		152'h05_24_00_10_01_05_24_01_00_00_04_24_02_00_05_24_06_01_00;
	localparam logic [47:0] VENDOR_BLOB = 48'h06_FF_00_00_00_00;
	localparam logic [7:0] REQ_GET_STATUS = 8'h00;
	localparam logic [7:0] REQ_SET_ADDRESS = 8'h05;
	localparam logic [7:0] REQ_GET_DESC = 8'h06;
	localparam logic [7:0] REQ_GET_CONFIG = 8'h08;
	localparam logic [7:0] REQ_SET_CONFIG = 8'h09;
	typedef struct packed {
		logic [7:0] reqType;
		logic [7:0] request;
		logic [15:0] value;
		logic [15:0] index;
		logic [15:0] length;
	} usbd_setup_t;
	typedef struct packed {
		logic valid;
		logic last;
		logic zlp;
		logic [7:0] data;
	} usbd_tx_t;
	typedef enum logic [1:0] {SRC_DEVICE, SRC_CONFIG, SRC_REPLY} usbd_src_t;
	typedef enum logic [2:0] {
		PH_IDLE, PH_SEND, PH_WAIT_IN, PH_STATUS, PH_STALL
	} usbd_phase_t;
endpackage

/* testbench/usbd_descriptor_enumeration_tb_top.sv */
// Self-checking bench for the enumeration engine
`timescale 1ns/1ps
module usbd_descriptor_enumeration_tb_top;
	localparam logic [15:0] VID = 16'hABCD; // Arbitrary value
	localparam logic [15:0] PID = 16'h5A3C; // Arbitrary value
	localparam logic [143:0] DEV = {64'h12_01_10_01_02_00_FF_40,
		VID[7:0], VID[15:8], PID[7:0], PID[15:8], 48'h00_01_01_02_00_01};
	localparam logic [199:0] CFG = {96'h09_02_57_00_02_01_03_A0_7D_09_04_00,
		104'h00_04_0A_00_00_04_07_05_81_02_40_00_00};
	logic clock = 1'h0;
	logic reset_n = 1'h0;
	logic setupValid = 1'h0;
	usbd_pkg::usbd_setup_t setup = '0;
	logic inReq = 1'h0;
	logic statusDone = 1'h0;
	logic extPowerGood = 1'h1;
	logic productIdValid = 1'h0;
	usbd_pkg::usbd_tx_t tx;
	logic stall;
	logic selfPowered;
	logic configured;
	logic [6:0] address;
	logic [7:0] currentConfig;
	logic [3:0] epEnable;
	int badCount = 0;
	int checks = 0;
	int cycles = 0;
	always #10 clock = ~clock;
	usbd_enum_ctrl #(.VENDOR_ID(VID)) usbd_enum_ctrl_i (.clock(clock),
		.reset_n(reset_n), .setupValid(setupValid), .setup(setup),
		.inReq(inReq), .statusDone(statusDone), .extPowerGood(extPowerGood),
		.productIdValid(productIdValid), .productIdIn(PID), .tx(tx),
		.stall(stall), .selfPowered(selfPowered), .address(address),
		.currentConfig(currentConfig), .configured(configured),
		.epEnable(epEnable));
	usbd_host_model usbd_host_model_i (.clock(clock), .tx(tx));
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			badCount++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("Checks %0d mismatches %0d", checks, badCount);
		if (badCount == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	function automatic logic [15:0] got();
		return 16'(usbd_host_model_i.rxBuf.size());
	endfunction
	task automatic request(input logic [7:0] rt, rq, input logic [15:0] v, n);
		setup = {rt, rq, v, 16'h0000, n};
		setupValid = 1'h1;
		tick(1);
		setupValid = 1'h0;
		usbd_host_model_i.rxBuf.delete();
	endtask
	task automatic inPacket();
		inReq = 1'h1;
		tick(1);
		inReq = 1'h0;
		for (int i = 0; i < 80 && !(tx.valid && tx.last); i++)
			tick(1);
		tick(1);
	endtask
	task automatic status();
		statusDone = 1'h1;
		tick(1);
		statusDone = 1'h0;
		tick(1);
	endtask
	task automatic bytes(input string what, input logic [199:0] exp, int n);
		for (int k = 0; k < n && k < got(); k++)
			check(what, {8'h00, usbd_host_model_i.rxBuf[k]},
				{8'h00, exp[(n-1-k)*8 +: 8]});
	endtask
	task automatic testDevice();
		request(8'h80, 8'h06, 16'h0100, 16'h0008);
		inPacket();
		check("short count", got(), 16'h0008);
		bytes("short", 200'(DEV[143:80]), 8);
		status();
		$display("Done device");
	endtask
	task automatic testAddress();
		request(8'h00, 8'h05, 16'h0005, 16'h0000);
		tick(2);
		check("addr early", 16'(address), 16'h0000);
		status();
		check("addr", 16'(address), 16'h0005);
		request(8'h80, 8'h06, 16'h0100, 16'h0040);
		inPacket();
		check("dev count", got(), 16'h0012);
		bytes("dev", 200'(DEV), 18);
		status();
		$display("Done address");
	endtask
	task automatic testConfig();
		int pkts;
		request(8'h80, 8'h06, 16'h0200, 16'h00FF);
		pkts = usbd_host_model_i.packets;
		inPacket();
		check("cfg first", got(), 16'h0040);
		inPacket();
		check("cfg pkts", 16'(usbd_host_model_i.packets - pkts), 16'h0002);
		check("cfg count", got(), 16'h0057);
		bytes("cfg", CFG, 25);
		status();
		request(8'h00, 8'h09, 16'h0001, 16'h0000);
		check("cfg early", 16'(currentConfig), 16'h0000);
		status();
		check("cfg value", 16'(currentConfig), 16'h0001);
		check("configured", 16'(configured), 16'h0001);
		check("endpoints", 16'(epEnable), 16'h000F);
		request(8'h80, 8'h08, 16'h0000, 16'h0001);
		inPacket();
		check("get cfg", {8'h00, usbd_host_model_i.rxBuf[0]}, 16'h0001);
		status();
		$display("Done config");
	endtask
	task automatic testPower();
		extPowerGood = 1'h0;
		request(8'h80, 8'h00, 16'h0000, 16'h0002);
		inPacket();
		check("stat count", got(), 16'h0002);
		bytes("stat", 200'h0, 2);
		check("self", 16'(selfPowered), 16'h0000);
		status();
		request(8'hA1, 8'h01, 16'h0000, 16'h0040);
		tick(1);
		check("stall", 16'(stall), 16'h0001);
		$display("Done power");
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			badCount++;
			summarize();
		end
	end
	initial begin
		tick(10);
		reset_n = 1'h1;
		productIdValid = 1'h1;
		tick(1);
		productIdValid = 1'h0;
		check("rst addr", 16'(address), 16'h0000);
		check("rst eps", 16'(epEnable), 16'h0001);
		testDevice();
		testAddress();
		testConfig();
		testPower();
		summarize();
	end
endmodule

/* testbench/usbd_host_model.sv */
// Host-side capture of control data stage bytes
`timescale 1ns/1ps
module usbd_host_model (
	input wire logic clock,
	input wire usbd_pkg::usbd_tx_t tx
);
	logic [7:0] rxBuf[$];
	int packets = 0;
	// Byte with last closes a packet
	always @(posedge clock) begin
		if (tx.valid) begin
			rxBuf.push_back(tx.data);
			if (tx.last)
				packets++;
		end
	end
endmodule
